// File: logic/analyzer_defs.vh
// Constants for the analyzer run control and dy counting block
`ifndef ANALYZER_DEFS_VH
`define ANALYZER_DEFS_VH

// Clock and bit time
`define SYS_CLK_MHZ        25
`define BIT_TIME_NS        160
`define BIT_DIV            ((`BIT_TIME_NS * `SYS_CLK_MHZ) / 1000)
`define BIT_DIV_W          4

// Register offsets (byte addresses)
`define REG_SWITCH         8'h00
`define REG_STATUS         8'h04
`define REG_DY             8'h08
`define REG_COUNTERS       8'h0c

// Switch register fields and reset value
`define SWITCH_LSB         0
`define SWITCH_MSB         3
`define SWITCH_RESET       4'hf

// Status register fields
`define ST_RUN_BIT         0
`define ST_STEP_BIT        1
`define ST_PHASE1_BIT      2
`define ST_PHASE2_BIT      3
`define ST_FIRST_WORD_BIT  4
`define ST_OVERFLOW_BIT    5

// Dy register fields
`define DY_LSB             0
`define DY_MSB             3

// Counter values, four bits each, counter 1 lowest
`define CNT_W              4

// Ones' complement step addends
`define STEP_UP            5'h01
`define STEP_DOWN          5'h0e

`endif

// File: logic/dy_count_cell.v
// One four-stage ones' complement dy counter
`timescale 1ns/1ps
`include "analyzer_defs.vh"

module dy_count_cell (
  input  wire                 sys_clk,
  input  wire                 sys_rst,
  input  wire                 bit_tick,
  input  wire                 count_en,
  input  wire                 count_neg,
  input  wire                 dump,
  output reg  [`CNT_W-1:0]    value
);

  wire [`CNT_W:0]   raw_sum;
  wire [`CNT_W-1:0] next_value;

  // End-around carry keeps the count in ones' complement
  assign raw_sum    = {1'b0, value} + (count_neg ? `STEP_DOWN : `STEP_UP);
  assign next_value = raw_sum[`CNT_W-1:0]
                      + {{(`CNT_W-1){1'b0}}, raw_sum[`CNT_W]};

  always @(posedge sys_clk) begin
    if (sys_rst) begin
      value <= {`CNT_W{1'b0}};
    end else if (bit_tick) begin
      if (dump) begin
        value <= {`CNT_W{1'b0}};
      end else if (count_en) begin
        value <= next_value;
      end
    end
  end

endmodule // dy_count_cell

// File: logic/analyzer_control.v
// Run control, phase timing and dy counters of the analyzer
`timescale 1ns/1ps
`include "analyzer_defs.vh"

// Notes on behaviour
// - Start command at sync time sets run.
// - Computation waits until step flip-flop is set.
// - Step resets at sign time and sync.
// - Halt command at sync time resets run.
// - Integrand overflow resets run, flags host overflow.
// - Nonzero dx counter one at sync halts.
// - Two phase flip-flops form local sign time.
// - Dump bit is phase two, not one, run.
// - First-word flag set at sync, cleared by phase-one set.
// - Lines ten to thirteen address counters four to one.
// - Address bit counts output increment, except sign/dump.
// - Sign-time address bit counts unmultiplied dz output.
// - Dump bit moves counter to dy register, clears it.
// - Lowest stage toggles on each coincidence; dump clears. Code adds with end-around carry: bit 0 holds on +0 down, +1 down, -0 up.
// - Negative counts ripple borrow through upper stages.
// - Dump clears counter, sets matching dy register bits.
// - Ones' complement counts; negative zero allowed.
// - First control-line pulse sets cleared step.
// - Output existence drives counter coincidence.
module analyzer_control (
  input  wire        sys_clk,
  input  wire        sys_rst,
  // Software register port
  input  wire [7:0]  reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_write,
  input  wire        reg_read,
  output reg  [31:0] reg_rdata,
  // Host command and timing inputs
  input  wire        host_start_cmd,
  input  wire        host_halt_cmd,
  input  wire        host_select,
  input  wire        host_last_word,
  input  wire        host_halt_condition,
  input  wire        integrand_overflow,
  input  wire        dx_first_existence_ff,
  // Drum lines
  input  wire        control_drum_line,
  input  wire        address_line_ten,
  input  wire        address_line_eleven,
  input  wire        address_line_twelve,
  input  wire        address_line_thirteen,
  // Output register of the integrators
  input  wire        output_exists,
  input  wire        output_negative,
  input  wire        integrator_output_increment,
  input  wire        unmultiplied_exists,
  input  wire        unmultiplied_negative,
  // Outputs
  output reg         run_n,
  output reg         step_enable_ff,
  output reg         sign_time_n,
  output reg         dump_run,
  output reg         first_word_run,
  output reg         host_overflow_set,
  output reg  [3:0]  dy_register
);

  // Bit time divider
  reg  [`BIT_DIV_W-1:0] div_count;
  reg                   bit_tick;

  // Control state
  reg                   run;
  reg                   phase_one_ff;
  reg                   phase_two_ff;
  reg                   first_word_flag;
  reg                   overflow_seen;
  reg  [3:0]            switch_enable;

  // Decoded timing
  wire                  sign_bit_time;
  wire                  dump_bit_time;
  wire                  sync_time_zero;
  wire                  phase_one_set;
  wire                  output_positive;

  // Next values
  reg                   next_run;
  reg                   next_step;
  reg                   next_phase_one;
  reg                   next_phase_two;
  reg                   next_first_word;

  // Counters, index 0 is counter one
  wire [3:0]            address_line;
  wire [3:0]            line_active;
  wire [3:0]            count_en;
  wire [3:0]            dump_en;
  wire [3:0]            cnt_value [0:3];
  wire                  count_sign;
  wire                  count_exists;
  reg  [3:0]            dump_merge;
  reg  [31:0]           next_rdata;
  integer               k;

  // Register offset decode, shared by read and write paths
  function hit;
    input [7:0] addr;
    input [7:0] offset;
    begin
      hit = (addr == offset);
    end
  endfunction

  // Divider giving one enable pulse per drum bit time
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      div_count <= {`BIT_DIV_W{1'b0}};
      bit_tick  <= 1'b0;
    end else if (div_count == `BIT_DIV - 1) begin
      div_count <= {`BIT_DIV_W{1'b0}};
      bit_tick  <= 1'b1;
    end else begin
      div_count <= div_count + {{(`BIT_DIV_W-1){1'b0}}, 1'b1};
      bit_tick  <= 1'b0;
    end
  end

  // Sign time is both phases; dump time is phase two alone
  assign sign_bit_time  = phase_one_ff & phase_two_ff;
  assign dump_bit_time  = phase_two_ff & ~phase_one_ff;
  assign sync_time_zero = dump_bit_time & host_last_word
                          & ~host_halt_condition;
  assign phase_one_set  = step_enable_ff & control_drum_line
                          & ~phase_one_ff;

  // Run flip-flop
  always @* begin
    next_run = run;
    if (sync_time_zero && host_start_cmd && host_select) begin
      next_run = 1'b1;
    end
    if (sync_time_zero && run && dx_first_existence_ff) begin
      next_run = 1'b0;
    end
    if (sync_time_zero && host_halt_cmd && host_select) begin
      next_run = 1'b0;
    end
  end

  // Step flip-flop: first control pulse sets it, timing clears it
  always @* begin
    next_step = step_enable_ff;
    if (!step_enable_ff && control_drum_line) begin
      next_step = 1'b1;
    end
    if (sign_bit_time || sync_time_zero) begin
      next_step = 1'b0;
    end
  end

  // Phase pair: one covers T27 and T28, two covers T28 and T29
  always @* begin
    next_phase_one = phase_one_ff;
    next_phase_two = phase_two_ff;
    if (phase_one_set) begin
      next_phase_one = 1'b1;
    end else if (phase_one_ff && phase_two_ff) begin
      next_phase_one = 1'b0;
    end
    if (phase_one_ff && !phase_two_ff) begin
      next_phase_two = 1'b1;
    end else if (phase_two_ff && !phase_one_ff) begin
      next_phase_two = 1'b0;
    end
  end

  // First-word flag: the sync set wins over the phase-one clear
  always @* begin
    next_first_word = first_word_flag;
    if (phase_one_set) begin
      next_first_word = 1'b0;
    end
    if (sync_time_zero) begin
      next_first_word = 1'b1;
    end
  end

  // Bit-time state update; overflow acts at once, not on the tick
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      run             <= 1'b0;
      step_enable_ff  <= 1'b0;
      phase_one_ff    <= 1'b0;
      phase_two_ff    <= 1'b0;
      first_word_flag <= 1'b0;
    end else begin
      if (integrand_overflow) begin
        run <= 1'b0;
      end else if (bit_tick) begin
        run <= next_run;
      end
      if (bit_tick) begin
        step_enable_ff  <= next_step;
        phase_one_ff    <= next_phase_one;
        phase_two_ff    <= next_phase_two;
        first_word_flag <= next_first_word;
      end
    end
  end

  // Registered copies of the timing outputs
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      run_n             <= 1'b1;
      sign_time_n       <= 1'b1;
      dump_run          <= 1'b0;
      first_word_run    <= 1'b0;
      host_overflow_set <= 1'b0;
      overflow_seen     <= 1'b0;
    end else begin
      run_n             <= ~run;
      sign_time_n       <= ~sign_bit_time;
      dump_run          <= dump_bit_time & run;
      first_word_run    <= first_word_flag & run;
      host_overflow_set <= integrand_overflow & run;
      if (integrand_overflow) begin
        overflow_seen <= 1'b1;
      end else if (reg_write && hit(reg_addr, `REG_STATUS)) begin
        overflow_seen <= 1'b0;
      end
    end
  end

  // Line ten drives counter four down to line thirteen for counter one
  assign address_line = {address_line_ten, address_line_eleven,
                         address_line_twelve,
                         address_line_thirteen};
  assign line_active  = address_line & switch_enable;

  // Existence gates counting; positive is existence without negative
  assign output_positive = output_exists & ~output_negative;
  assign count_exists    = sign_bit_time ? unmultiplied_exists
                           : (output_exists & integrator_output_increment);
  assign count_sign      = sign_bit_time ? unmultiplied_negative
                           : ~output_positive;

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : gen_dy
      // Ordinary positions count the increment, sign time counts dz
      assign count_en[g] = run & line_active[g] & count_exists
                           & ~dump_bit_time;
      assign dump_en[g]  = run & line_active[g] & dump_bit_time;

      dy_count_cell u_cell (
        .sys_clk   (sys_clk),
        .sys_rst   (sys_rst),
        .bit_tick  (bit_tick),
        .count_en  (count_en[g]),
        .count_neg (count_sign),
        .dump      (dump_en[g]),
        .value     (cnt_value[g])
      );
    end
  endgenerate

  // Bits of every counter dumped in this bit time are merged
  always @* begin
    dump_merge = 4'h0;
    for (k = 0; k < 4; k = k + 1) begin
      if (dump_en[k]) begin
        dump_merge = dump_merge | cnt_value[k];
      end
    end
  end

  // Dy register takes the dumped count at dump time
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      dy_register <= 4'h0;
    end else if (bit_tick && (dump_en != 4'h0)) begin
      dy_register <= dump_merge;
    end
  end

  // Switch register write
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      switch_enable <= `SWITCH_RESET;
    end else if (reg_write && hit(reg_addr, `REG_SWITCH)) begin
      switch_enable <= reg_wdata[`SWITCH_MSB:`SWITCH_LSB];
    end
  end

  // Read data, valid the cycle after the read strobe
  always @* begin
    next_rdata = 32'h0000_0000;
    if (hit(reg_addr, `REG_SWITCH)) begin
      next_rdata[`SWITCH_MSB:`SWITCH_LSB] = switch_enable;
    end else if (hit(reg_addr, `REG_STATUS)) begin
      next_rdata[`ST_RUN_BIT]        = run;
      next_rdata[`ST_STEP_BIT]       = step_enable_ff;
      next_rdata[`ST_PHASE1_BIT]     = phase_one_ff;
      next_rdata[`ST_PHASE2_BIT]     = phase_two_ff;
      next_rdata[`ST_FIRST_WORD_BIT] = first_word_flag;
      next_rdata[`ST_OVERFLOW_BIT]   = overflow_seen;
    end else if (hit(reg_addr, `REG_DY)) begin
      next_rdata[`DY_MSB:`DY_LSB] = dy_register;
    end else if (hit(reg_addr, `REG_COUNTERS)) begin
      next_rdata[15:0] = {cnt_value[3], cnt_value[2],
                          cnt_value[1], cnt_value[0]};
    end
  end

  always @(posedge sys_clk) begin
    if (sys_rst) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_read) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

endmodule // analyzer_control

// File: verification/analyzer_control_sva.sv
// Checker for run control, phase timing and dy dumping
`timescale 1ns/1ps
module analyzer_control_sva (
  input logic       sys_clk,
  input logic       sys_rst,
  input logic       host_start_cmd,
  input logic       host_select,
  input logic       host_last_word,
  input logic       host_halt_condition,
  input logic       integrand_overflow,
  input logic       control_drum_line,
  input logic       run_n,
  input logic       step_enable_ff,
  input logic       sign_time_n,
  input logic       dump_run,
  input logic       first_word_run,
  input logic       host_overflow_set,
  input logic [3:0] dy_register
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  sequence s_sync_start;
    $past(host_start_cmd, 2) && $past(host_select, 2) &&
      $past(host_last_word, 2) && !$past(host_halt_condition, 2);
  endsequence
  sequence s_sign_window;
    !sign_time_n [*4] ##1 sign_time_n;
  endsequence
  property p_start_sync;
    $fell(run_n) |-> s_sync_start;
  endproperty
  a_start_sync: assert property (p_start_sync)
    else $error("run began without a start at sync");
  property p_step_cause;
    $rose(step_enable_ff) |-> $past(control_drum_line);
  endproperty
  a_step_cause: assert property (p_step_cause)
    else $error("step set without a control pulse");
  property p_step_clear;
    !sign_time_n |-> ##[0:4] !step_enable_ff;
  endproperty
  a_step_clear: assert property (p_step_clear)
    else $error("step not cleared at sign time");
  property p_ovf_halt;
    integrand_overflow && !run_n |-> ##[1:2] run_n;
  endproperty
  a_ovf_halt: assert property (p_ovf_halt)
    else $error("overflow did not stop the run");
  property p_ovf_flag;
    integrand_overflow && !run_n |-> ##[1:2] host_overflow_set;
  endproperty
  a_ovf_flag: assert property (p_ovf_flag)
    else $error("overflow not passed to the host");
  property p_sign_len;
    $fell(sign_time_n) |-> s_sign_window;
  endproperty
  a_sign_len: assert property (p_sign_len)
    else $error("sign time not one bit time long");
  property p_dump_follows;
    $rose(sign_time_n) && !run_n |-> dump_run && !run_n;
  endproperty
  a_dump_follows: assert property (p_dump_follows)
    else $error("dump time missing after sign time");
  property p_first_clear;
    $fell(first_word_run) && !run_n |-> ##[1:8] !sign_time_n;
  endproperty
  a_first_clear: assert property (p_first_clear)
    else $error("first word flag cleared off the phase start");
  property p_dy_load;
    $changed(dy_register) |-> ##[0:1] dump_run;
  endproperty
  a_dy_load: assert property (p_dy_load)
    else $error("dy register changed outside dump time");
endmodule // analyzer_control_sva
bind analyzer_control analyzer_control_sva u_sva (
  .sys_clk(sys_clk), .sys_rst(sys_rst), .host_start_cmd(host_start_cmd),
  .host_select(host_select), .host_last_word(host_last_word),
  .host_halt_condition(host_halt_condition),
  .integrand_overflow(integrand_overflow),
  .control_drum_line(control_drum_line), .run_n(run_n),
  .step_enable_ff(step_enable_ff), .sign_time_n(sign_time_n),
  .dump_run(dump_run), .first_word_run(first_word_run),
  .host_overflow_set(host_overflow_set), .dy_register(dy_register));

// File: verification/host_drum_model.sv
// Host drum model: control line, word timing and address lines
`timescale 1ns/1ps
module host_drum_model (
  input  logic       sys_clk,
  input  logic       sys_rst,
  input  logic       run_n,
  input  logic [3:0] addr_mask,
  input  logic [3:0] dump_mask,
  output logic [2:0] slot,
  output logic [1:0] word,
  output logic       control_drum_line,
  output logic       host_last_word,
  output logic [3:0] address_lines
);
  logic [1:0] div;
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      div  <= 2'h0;
      slot <= 3'h0;
      word <= 2'h0;
    end else begin
      div <= div + 2'h1;
      if (div == 2'h3) begin
        slot <= slot + 3'h1;
        if (slot == 3'h7)
          word <= word + 2'h1;
      end
    end
  end
  // Start pulse then clear bit at the head of every word
  assign control_drum_line = (slot == 3'h0) || (slot == 3'h1);
  assign host_last_word = (word == 2'h3);
  // Slot three is sign time and slot four dump time as the block sees them
  // Count bits in word one, dumps in word two, blank while stopped
  assign address_lines = run_n ? 4'h0 :
    (word == 2'h1 && slot != 3'h4) ? addr_mask :
    (word == 2'h2 && slot == 3'h4) ? dump_mask : 4'h0;
endmodule // host_drum_model

// File: verification/analyzer_control_tb.sv
// Self-checking bench for analyzer run control and dy counters
`timescale 1ns/1ps
module analyzer_control_tb;
  logic        sys_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_write = 1'b0;
  logic        reg_read = 1'b0;
  logic        host_start_cmd = 1'b0;
  logic        host_halt_cmd = 1'b0;
  logic        integrand_overflow = 1'b0;
  logic        dx_one = 1'b0;
  logic        output_negative = 1'b0;
  logic        unmult = 1'b0;
  logic        um_neg = 1'b0;
  logic        out_exists = 1'b1;
  logic        host_select = 1'b1;
  logic        halt_cond = 1'b0;
  logic [3:0]  addr_mask = 4'h0;
  logic [3:0]  dump_mask = 4'h0;
  logic [31:0] reg_rdata, seen, want;
  logic [3:0]  address_lines, dy_register, want_dy;
  logic [2:0]  slot;
  logic [1:0]  word;
  logic        ctl_line, last_word, run_n, first_word_run;
  int          fails = 0;
  int          n_tests = 0;
  always #20 sys_clk = ~sys_clk;
  analyzer_control dut (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .host_start_cmd(host_start_cmd),
    .host_halt_cmd(host_halt_cmd), .host_select(host_select),
    .host_last_word(last_word), .host_halt_condition(halt_cond),
    .integrand_overflow(integrand_overflow),
    .dx_first_existence_ff(dx_one), .control_drum_line(ctl_line),
    .address_line_ten(address_lines[0]),
    .address_line_eleven(address_lines[1]),
    .address_line_twelve(address_lines[2]),
    .address_line_thirteen(address_lines[3]),
    .output_exists(out_exists), .output_negative(output_negative),
    .integrator_output_increment(1'b1), .unmultiplied_exists(unmult),
    .unmultiplied_negative(um_neg), .run_n(run_n), .step_enable_ff(),
    .sign_time_n(), .dump_run(), .first_word_run(first_word_run),
    .host_overflow_set(), .dy_register(dy_register));
  host_drum_model host (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .run_n(run_n),
    .addr_mask(addr_mask), .dump_mask(dump_mask), .slot(slot),
    .word(word), .control_drum_line(ctl_line),
    .host_last_word(last_word), .address_lines(address_lines));
  task automatic check(input string what, input logic [31:0] exp_v,
                       input logic [31:0] got);
    n_tests++;
    if (got !== exp_v) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp_v, got);
    end
  endtask
  task automatic access(input logic wr, input logic [7:0] a,
                        input logic [31:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_write <= wr;
    reg_read  <= !wr;
    @(posedge sys_clk);
    reg_write <= 1'b0;
    reg_read  <= 1'b0;
    @(posedge sys_clk);
    seen = reg_rdata;
  endtask
  task automatic wait_at(input logic [1:0] w, input logic [2:0] s);
    int n;
    for (n = 0; n < 600 && !(word == w && slot == s); n++)
      @(posedge sys_clk);
    if (n == 600)
      fails++;
    @(posedge sys_clk);
  endtask
  task automatic start_run;
    host_start_cmd <= 1'b1;
    wait_at(2'h3, 3'h2);
    check("run_n early", 32'h1, {31'h0, run_n});
    wait_at(2'h3, 3'h5);
    check("run_n", 32'h0, {31'h0, run_n});
    check("first_word_run", 32'h1, {31'h0, first_word_run});
    host_start_cmd <= 1'b0;
    access(1'b0, 8'h04, 32'h0);
    check("status", 32'h11, seen);
  endtask
  task automatic final_report;
    if (fails == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    check("run_n reset", 32'h1, {31'h0, run_n});
    access(1'b0, 8'h00, 32'h0);
    check("switch", 32'hf, seen);
    access(1'b1, 8'h00, 32'h5);
    access(1'b0, 8'h00, 32'h0);
    check("switch", 32'h5, seen);
    access(1'b1, 8'h00, 32'hf);
    access(1'b0, 8'h10, 32'h0);
    check("unmapped", 32'h0, seen);
    // A start without select, then one under a halt condition
    for (int k = 0; k < 2; k++) begin
      host_start_cmd <= 1'b1;
      host_select    <= (k == 1);
      halt_cond      <= (k == 1);
      wait_at(2'h3, 3'h2);
      wait_at(2'h3, 3'h6);
      check("run_n blocked", 32'h1, {31'h0, run_n});
    end
    host_select <= 1'b1;
    halt_cond   <= 1'b0;
    start_run();
    // Lines ten to thirteen in turn, a negative run to minus seven,
    // then a positive dz count with no ordinary output
    for (int k = 0; k < 6; k++) begin
      wait_at(2'h0, 3'h4);
      addr_mask       <= 4'h1 << (k % 4);
      dump_mask       <= 4'hf;
      output_negative <= (k == 4);
      out_exists      <= (k != 5);
      unmult          <= (k >= 4);
      um_neg          <= (k == 4);
      want_dy = (k == 4) ? 4'h8 : (k == 5) ? 4'h1 : 4'h6;
      want = {28'h0, want_dy} << (4 * (3 - k % 4));
      wait_at(2'h2, 3'h1);
      check("first_word_run", 32'h0, {31'h0, first_word_run});
      access(1'b0, 8'h0c, 32'h0);
      check("counters", want, seen);
      wait_at(2'h2, 3'h5);
      check("dy", {28'h0, want_dy}, {28'h0, dy_register});
      access(1'b0, 8'h0c, 32'h0);
      check("counters cleared", 32'h0, seen);
    end
    addr_mask          <= 4'h0;
    out_exists         <= 1'b1;
    integrand_overflow <= 1'b1;
    @(posedge sys_clk);
    integrand_overflow <= 1'b0;
    repeat (2) @(posedge sys_clk);
    check("run_n overflow", 32'h1, {31'h0, run_n});
    access(1'b0, 8'h04, 32'h0);
    check("overflow seen", 32'h1, {31'h0, seen[5]});
    access(1'b1, 8'h04, 32'h0);
    access(1'b0, 8'h04, 32'h0);
    check("overflow cleared", 32'h0, {31'h0, seen[5]});
    for (int k = 0; k < 2; k++) begin
      start_run();
      host_halt_cmd <= (k == 0);
      dx_one        <= (k == 1);
      wait_at(2'h3, 3'h2);
      check("run_n before sync", 32'h0, {31'h0, run_n});
      wait_at(2'h3, 3'h5);
      check("run_n halted", 32'h1, {31'h0, run_n});
      host_halt_cmd <= 1'b0;
      dx_one        <= 1'b0;
    end
    final_report();
  end
  initial begin
    #500us;
    fails++;
    final_report();
  end
endmodule // analyzer_control_tb
